// ---- core/osd_timing_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the OSD
// scroll and sync control block.
// Assumes a 16-bit register address and 8-bit data from the processor core.
`ifndef OSD_TIMING_CFG_SVH
`define OSD_TIMING_CFG_SVH

`define ADDR_CONTROL      16'h87f8
`define ADDR_HSYNC_DELAY  16'h87fc
`define ADDR_ALIGN_DELAY  16'h87fd
`define ADDR_SCROLL_ROWS  16'h87fa

`define BIT_BUSY_SEL      6
`define BIT_SCROLL_AREA   5
`define BIT_SCROLL_CTRL   4
`define BIT_BUSY_RD       7
`define BIT_FIELD_RD      5

`define RST_CONTROL       8'h00
`define RST_DELAY         7'h00
`define RST_ROWS          4'h0

`define CHAR_CLKS         8'd12
`define ALIGN_STEP_CLKS   8'd12
`define LINE_CLKS         12'd3178
`define LINES_PER_FIELD   10'd262
`define VBLANK_LINES      10'd21
`define HBLANK_CLKS       12'd600
`define SCROLL_STEP_LINES 4'd8
`define LEAD_TIME_US      4000
`define CLK_MHZ           50
`define LEAD_CLKS         ((`LEAD_TIME_US) * (`CLK_MHZ))

`endif

// ---- core/osd_timing_pkg.sv ----
// Types shared by the OSD scroll and sync control block.
// Assumes the constants header is available to the same compile.
package osd_timing_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic       busy_sel;
		logic       scroll_area;
	} ctrl_t;

	typedef enum logic [1:0] {
		SCR_IDLE,
		SCR_RUN,
		SCR_DONE
	} scroll_state_t;
endpackage

// ---- core/osd_scroll_sync_control.sv ----
// OSD scroll and sync control: register slave, scroll engine, line timing
// with delayed horizontal sync and delayed mid-line pulse.
// Assumes one 50 MHz clock, synchronous reset, same-clock register master.
`include "osd_timing_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module osd_scroll_sync_control
	import osd_timing_pkg::*;
#(
	parameter int LEAD_CLKS = `LEAD_CLKS
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire reg_req_t    req,
	output var  logic [7:0]  rdata,
	output var  logic        busy,
	output var  logic        scroll_area_enable,
	output var  logic [3:0]  first_scroll_row,
	output var  logic        hsync,
	output var  logic        mid_line_pulse,
	output var  logic        field_odd
);

	//==========================================================
	// Register slave
	ctrl_t         ctrl_ff;
	logic [6:0]    hsd_ff;
	logic [6:0]    oea_ff;
	logic [3:0]    start_row_ff;
	logic [3:0]    stop_row_ff;
	logic [7:0]    rdata_ff;
	logic [7:0]    nxt_rdata;
	logic [7:0]    status_rd;
	logic          wr_ctrl;
	logic          wr_hsync;
	logic          wr_align;
	logic          wr_rows;
	logic          scroll_on;
	logic          busy_ff;
	logic          field_ff;
	logic [3:0]    row_ff;

	// Write decode; control and status fields share one address
	assign wr_ctrl  = req.wr && req.addr == `ADDR_CONTROL;
	assign wr_hsync = req.wr && req.addr == `ADDR_HSYNC_DELAY;
	assign wr_align = req.wr && req.addr == `ADDR_ALIGN_DELAY;
	assign wr_rows  = req.wr && req.addr == `ADDR_SCROLL_ROWS;

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_ff <= '0;
		end else if (wr_ctrl) begin
			// Bits 7 and 3..0 are dropped
			ctrl_ff.busy_sel    <= req.wdata[`BIT_BUSY_SEL];
			ctrl_ff.scroll_area <= req.wdata[`BIT_SCROLL_AREA];
		end
	end

	// Bit 7 of both delay registers is reserved and never stored
	always_ff @(posedge clock) begin
		if (srst) begin
			hsd_ff <= `RST_DELAY;
		end else if (wr_hsync) begin
			hsd_ff <= req.wdata[6:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			oea_ff <= `RST_DELAY;
		end else if (wr_align) begin
			oea_ff <= req.wdata[6:0];
		end
	end

	// Scroll window limits
	always_ff @(posedge clock) begin
		if (srst) begin
			start_row_ff <= `RST_ROWS;
		end else if (wr_rows) begin
			start_row_ff <= req.wdata[3:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			stop_row_ff <= `RST_ROWS;
		end else if (wr_rows) begin
			stop_row_ff <= req.wdata[7:4];
		end
	end

	// Status side of the shared address: busy, field, scroll busy, row
	assign status_rd = {busy_ff, 1'b0, field_ff, scroll_on, row_ff};

	always_comb begin
		nxt_rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				`ADDR_CONTROL:     nxt_rdata = status_rd;
				`ADDR_HSYNC_DELAY: nxt_rdata = {1'b0, hsd_ff};
				`ADDR_ALIGN_DELAY: nxt_rdata = {1'b0, oea_ff};
				`ADDR_SCROLL_ROWS: nxt_rdata = {stop_row_ff, start_row_ff};
				default:           nxt_rdata = 8'h00;
			endcase
		end
	end

	// Read data stand one cycle and return to zero
	always_ff @(posedge clock) begin
		if (srst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	//==========================================================
	// Line and field timing
	logic [11:0]   hcnt_ff;
	logic [9:0]    vcnt_ff;
	logic          line_end;
	logic          field_end;

	assign line_end  = hcnt_ff == `LINE_CLKS - 12'd1;
	assign field_end = line_end && vcnt_ff == `LINES_PER_FIELD - 10'd1;

	// Clock count within a line
	always_ff @(posedge clock) begin
		if (srst) begin
			hcnt_ff <= 12'h000;
		end else if (line_end) begin
			hcnt_ff <= 12'h000;
		end else begin
			hcnt_ff <= hcnt_ff + 12'd1;
		end
	end

	// Line count within a field
	always_ff @(posedge clock) begin
		if (srst) begin
			vcnt_ff <= 10'h000;
		end else if (field_end) begin
			vcnt_ff <= 10'h000;
		end else if (line_end) begin
			vcnt_ff <= vcnt_ff + 10'd1;
		end
	end

	// Field toggles once per field
	always_ff @(posedge clock) begin
		if (srst) begin
			field_ff <= 1'b0;
		end else if (field_end) begin
			field_ff <= ~field_ff;
		end
	end

	//==========================================================
	// Delayed sync and mid-line pulse
	logic [11:0]   hsync_pos;
	logic [11:0]   mid_pos;
	logic          hsync_ff;
	logic          mid_ff;

	// Values above 63 are out of range; taken as programmed
	assign hsync_pos = 12'(hsd_ff) * 12'(`CHAR_CLKS);
	assign mid_pos   = 12'(`LINE_CLKS / 2)
		+ 12'(oea_ff) * 12'(`ALIGN_STEP_CLKS);

	// Both pulses are one clock wide, one flip-flop after the compare
	always_ff @(posedge clock) begin
		if (srst) begin
			hsync_ff <= 1'b0;
		end else begin
			hsync_ff <= hcnt_ff == hsync_pos;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			mid_ff <= 1'b0;
		end else begin
			mid_ff <= hcnt_ff == mid_pos;
		end
	end

	//==========================================================
	// Busy indication with lead time
	logic          in_blank;
	logic [31:0]   to_active;
	logic          nxt_busy;

	// Clocks left until the selected blanking interval ends
	always_comb begin
		if (ctrl_ff.busy_sel) begin
			in_blank  = vcnt_ff < `VBLANK_LINES;
			to_active = 32'(`VBLANK_LINES - vcnt_ff) * 32'(`LINE_CLKS)
				- 32'(hcnt_ff);
		end else begin
			in_blank  = hcnt_ff < `HBLANK_CLKS;
			to_active = 32'(`HBLANK_CLKS - hcnt_ff);
		end
	end

	// Free only inside blanking and more than the lead time before its
	// end, so that an access already started can still finish
	assign nxt_busy = !in_blank || to_active <= 32'(LEAD_CLKS);

	always_ff @(posedge clock) begin
		if (srst) begin
			busy_ff <= 1'b1;
		end else begin
			busy_ff <= nxt_busy;
		end
	end

	//==========================================================
	// Automatic scroll engine
	scroll_state_t state_ff;
	scroll_state_t nxt_state;
	logic [3:0]    nxt_row;
	logic [3:0]    step_ff;
	logic          step_tick;
	logic          stop_hit;
	logic          scroll_start;
	logic          scroll_abort;
	logic          row_bump;

	assign scroll_on    = state_ff == SCR_RUN;
	assign stop_hit     = row_ff == stop_row_ff;
	assign step_tick    = line_end
		&& step_ff == `SCROLL_STEP_LINES - 4'd1;
	// Control bits 7 and 3..0 play no part in these decodes
	assign scroll_start = wr_ctrl && req.wdata[`BIT_SCROLL_CTRL];
	assign scroll_abort = wr_ctrl && !req.wdata[`BIT_SCROLL_CTRL];
	// Zero writes step the row only once a scroll has ended
	assign row_bump     = scroll_abort && state_ff == SCR_DONE;

	always_comb begin
		nxt_state = state_ff;
		nxt_row   = row_ff;
		case (state_ff)
			SCR_IDLE, SCR_DONE: begin
				if (scroll_start) begin
					nxt_state = SCR_RUN;
					nxt_row   = start_row_ff;
				end else if (row_bump) begin
					nxt_row = row_ff + 4'd1;
				end
			end
			SCR_RUN: begin
				if (scroll_abort) begin
					// Same end state as a completed run
					nxt_state = SCR_DONE;
					nxt_row   = stop_row_ff;
				end else if (step_tick && stop_hit) begin
					nxt_state = SCR_DONE;
				end else if (step_tick) begin
					nxt_row = row_ff + 4'd1;
				end
			end
			default: begin
				nxt_state = SCR_IDLE;
				nxt_row   = row_ff;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_ff <= SCR_IDLE;
			row_ff   <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			row_ff   <= nxt_row;
		end
	end

	// Lines counted per scroll step; a fresh start begins a new step
	always_ff @(posedge clock) begin
		if (srst) begin
			step_ff <= 4'h0;
		end else if (scroll_start && state_ff != SCR_RUN) begin
			step_ff <= 4'h0;
		end else if (state_ff == SCR_RUN && line_end) begin
			step_ff <= step_tick ? 4'h0 : step_ff + 4'd1;
		end
	end

	//==========================================================
	// Outputs, each from a flip-flop of its own
	always_ff @(posedge clock) begin
		if (srst) begin
			scroll_area_enable <= 1'b0;
		end else begin
			scroll_area_enable <= ctrl_ff.scroll_area;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			first_scroll_row <= 4'h0;
		end else begin
			first_scroll_row <= row_ff;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			field_odd <= 1'b0;
		end else begin
			field_odd <= field_ff;
		end
	end

	// Remaining outputs are the flip-flops themselves

	assign rdata          = rdata_ff;
	assign busy           = busy_ff;
	assign hsync          = hsync_ff;
	assign mid_line_pulse = mid_ff;

endmodule

`default_nettype wire

// ---- verification/osd_scroll_sync_control_properties.sv ----
// Port checker for the OSD scroll and sync control block.
// Assumes one clock domain; bound to the design top module.
`timescale 1ns/100ps
`default_nettype none
module osd_sync_checker
	import osd_timing_pkg::*;
#(
	parameter int LEAD_CLKS = 50
) (
	input wire logic       clock,
	input wire logic       srst,
	input wire reg_req_t   req,
	input wire logic [7:0] rdata,
	input wire logic       busy,
	input wire logic       scroll_area_enable,
	input wire logic [3:0] first_scroll_row,
	input wire logic       hsync,
	input wire logic       mid_line_pulse,
	input wire logic       field_odd
);
	// ==========
	// Line length tracker, void after a sync delay write
	logic [11:0] gap_ff;
	logic        ok_ff;
	always_ff @(posedge clock) begin
		if (srst) begin
			gap_ff <= 12'h000;
			ok_ff  <= 1'b0;
		end else begin
			gap_ff <= hsync ? 12'h000 : gap_ff + 12'h001;
			ok_ff  <= (hsync || ok_ff) && !(req.wr && req.addr == 16'h87fc);
		end
	end
	// ==========
	// Properties
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	AST_HS_PERIOD: assert property (hsync && ok_ff |-> gap_ff == 12'd3177)
		else $error("hsync period wrong");
	AST_HS_ONE: assert property (hsync |=> !hsync)
		else $error("hsync too long");
	AST_MID_ONE: assert property (mid_line_pulse |=> !mid_line_pulse)
		else $error("mid pulse too long");
	AST_NO_OVERLAP: assert property (!(hsync && mid_line_pulse))
		else $error("pulses coincide");
	AST_RD_IDLE: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside read");
	AST_AREA: assert property (req.wr && req.addr == 16'h87f8 |-> ##2
		scroll_area_enable == $past(req.wdata[5], 2))
		else $error("area enable wrong");
	AST_STATUS: assert property ($past(req.rd) &&
		$past(req.addr) == 16'h87f8 |-> rdata[7] == $past(busy))
		else $error("status busy wrong");
	AST_ROW_STEP: assert property ($changed(first_scroll_row) |->
		$past(req.wr, 2) || first_scroll_row == $past(first_scroll_row) + 4'h1)
		else $error("row jumped");
endmodule
bind osd_scroll_sync_control osd_sync_checker #(.LEAD_CLKS(LEAD_CLKS)) chk (
	.clock(clock), .srst(srst), .req(req), .rdata(rdata), .busy(busy),
	.scroll_area_enable(scroll_area_enable), .hsync(hsync),
	.first_scroll_row(first_scroll_row), .mid_line_pulse(mid_line_pulse),
	.field_odd(field_odd));
`default_nettype wire

// ---- verification/osd_cpu_model.sv ----
// Processor core model issuing register writes and reads.
// Assumes read data arrive in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module osd_cpu_model
	import osd_timing_pkg::*;
(
	input  wire logic [7:0] rdata,
	input  wire logic       clock,
	output var  reg_req_t   req
);
	initial req = '0;
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		req.wr <= 1'b0;
	endtask
	task rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		req.rd <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// ---- verification/osd_scroll_sync_control_tb.sv ----
// Testbench for the OSD scroll and sync control block.
// Assumes the processor model and the bound checker in the same compile.
`timescale 1ns/100ps
`default_nettype none
module osd_scroll_sync_control_tb;
	import osd_timing_pkg::*;
	logic       clock, srst, busy, area, hs, mid, fodd;
	reg_req_t   req;
	logic [7:0] rdata, d;
	logic [3:0] row;
	logic [31:0] v;
	int         num_errors = 0, samples_checked = 0, cyc = 0, seed, n, i;
	osd_scroll_sync_control #(.LEAD_CLKS(50)) DUT (.clock(clock),
		.srst(srst), .req(req), .rdata(rdata), .busy(busy),
		.scroll_area_enable(area), .first_scroll_row(row), .hsync(hs),
		.mid_line_pulse(mid), .field_odd(fodd));
	osd_cpu_model cpu (.rdata(rdata), .clock(clock), .req(req));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 100000) begin
			num_errors++;
			results;
		end
	end
	function logic [15:0] off(input int h, input int a);
		return 16'((1589 + 12 * a - 12 * h) % 3178);
	endfunction
	task wait_for(input logic which);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while ((which ? mid : hs) !== 1'b1 && n < 4000);
	endtask
	initial begin
		seed = 32'hf328;
		srst = 1'b1;
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		check(busy, 1'b1);
		for (i = 0; i < 3; i++) begin
			v = $random(seed);
			if (i == 0)
				v = 32'h0000ffbf;
			cpu.wr(16'h87fc, {v[7], 1'b0, v[5:0]});
			cpu.wr(16'h87fd, v[15:8]);
			cpu.rd(16'h87fc, d);
			check(d, {2'b00, v[5:0]});
			cpu.rd(16'h87fd, d);
			check(d, {1'b0, v[14:8]});
			wait_for(1'b0);
			wait_for(1'b0);
			wait_for(1'b1);
			check(n[15:0], off(v[5:0], v[14:8]));
		end
		cpu.rd(16'h87f9, d);
		check(d, 8'h00);
		cpu.wr(16'h87f8, 8'h8f);
		n = 0;
		repeat (3178) @(negedge clock) if (busy === 1'b0) n++;
		check(n > 0, 1'b1);
		check(n[15:0], 16'd550);
		cpu.wr(16'h87fa, 8'h32);
		cpu.wr(16'h87f8, 8'h7f);
		cpu.rd(16'h87f8, d);
		check(d[4:0], 5'h12);
		check(d[5], fodd);
		check(area, 1'b1);
		n = 0;
		while (row !== 4'h3 && n < 30000) begin
			@(negedge clock);
			n++;
		end
		repeat (3) @(negedge clock);
		cpu.rd(16'h87f8, d);
		check(d[4:0], 5'h13);
		n = 0;
		do begin
			cpu.rd(16'h87f8, d);
			n++;
		end while (d[4] !== 1'b0 && n < 15000);
		check(d[4:0], 5'h03);
		cpu.wr(16'h87f8, 8'h20);
		repeat (3) @(negedge clock);
		check(row, 4'h4);
		cpu.wr(16'h87fa, 8'h95);
		cpu.wr(16'h87f8, 8'h30);
		cpu.wr(16'h87f8, 8'h20);
		cpu.rd(16'h87f8, d);
		check(d[4:0], 5'h09);
		cpu.wr(16'h87f8, 8'h00);
		cpu.rd(16'h87f8, d);
		check(d[4:0], 5'h0a);
		results;
	end
endmodule
`default_nettype wire
